// File: verilog/dfb_pkg.sv
`default_nettype none
// ==========================================================
// shared constants of the frame-buffer memory interface
package dfb_pkg;
   // data path widths
   localparam int DATA_W     = 16;   // frame buffer bus width
   localparam int BE_W       = 2;    // byte lanes
   localparam int FIFO_DEPTH = 32;   // write fifo depth in words
   localparam int ADDR_W     = 11;   // memory address pins
   localparam int EDO_ADDR_W = 10;   // pins used with edo memory
   localparam int ROW_W      = 11;   // row bits of word address
   localparam int COL_W      = 8;    // column bits of word address
   localparam int WADDR_W    = ROW_W + COL_W;
   // clock and times
   localparam int SYS_CLK_PS     = 4000;     // sys_clk period
   localparam int REF_PERIOD_NS  = 7800;     // refresh interval
   localparam int REF_CYCLES     = (REF_PERIOD_NS * 1000) / SYS_CLK_PS;
   localparam int INIT_WAIT_NS   = 100000;   // power-up pause
   localparam int INIT_CYCLES    =
      (INIT_WAIT_NS * 1000 + SYS_CLK_PS - 1) / SYS_CLK_PS;
   // command spacing, counted in memory clock ticks
   localparam logic [3:0] T_RCD   = 4'h2;   // activate to command
   localparam logic [3:0] CAS_LAT = 4'h2;   // read latency
   localparam logic [3:0] T_WR    = 4'h2;   // write hold
   localparam logic [3:0] T_RP    = 4'h2;   // precharge recovery
   localparam logic [3:0] T_RFC   = 4'h8;   // refresh duration
   localparam logic [1:0] INIT_REFS = 2'h2; // refreshes at init
   // mode word: burst of one, cas latency two
   localparam logic [10:0] MODE_WORD = 11'h020;
   localparam int          AP_BIT    = 10;  // auto precharge pin
   // controller states
   typedef enum logic [2:0] {
      DFB_POWERUP, DFB_PRECHG, DFB_MRS, DFB_IDLE,
      DFB_ACT, DFB_CMD, DFB_REF, DFB_RECOV
   } dfb_state_t;
endpackage
`default_nettype wire

// File: verilog/dfb_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// synchronous fifo, flip-flop storage, valid/ready both sides
module dfb_fifo #(
   parameter int W     = 18,
   parameter int DEPTH = 32
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic      [W-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];   // storage
   logic [PW:0]  wr_ptr;        // write pointer with wrap bit
   logic [PW:0]  rd_ptr;        // read pointer with wrap bit
   logic         push;
   logic         pop;

   // full when pointers differ only in wrap bit
   assign in_ready  = !((wr_ptr[PW] != rd_ptr[PW]) &&
                        (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]));
   assign out_valid = (wr_ptr != rd_ptr);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr[PW-1:0]];

   // ==========================================================
   // pointers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop)  rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // storage write
   always_ff @(posedge sys_clk) begin
      if (push) mem[wr_ptr[PW-1:0]] <= in_data;
   end
endmodule
`default_nettype wire

// File: verilog/dfb_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
module dfb_mem_if #(
   parameter int INIT_WAIT = dfb_pkg::INIT_CYCLES  // power-up cycles
) (
   input  wire logic                        sys_clk,
   input  wire logic                        rst_n,
   input  wire logic                        sdram_sel,
   input  wire logic                        dual_scan_en,
   input  wire logic                        frame_start,
   input  wire logic                        pix_valid,
   output logic                             pix_ready,
   input  wire logic [dfb_pkg::DATA_W-1:0]  pix_data,
   input  wire logic [dfb_pkg::BE_W-1:0]    pix_be,
   input  wire logic                        rd_req,
   output logic                             rd_valid,
   input  wire logic                        rd_ready,
   output logic      [dfb_pkg::DATA_W-1:0]  rd_data,
   output logic      [dfb_pkg::ADDR_W-1:0]  mem_addr_bus,
   input  wire logic [dfb_pkg::DATA_W-1:0]  frame_buffer_bus_in,
   output logic      [dfb_pkg::DATA_W-1:0]  frame_buffer_bus_out,
   output logic                             frame_buffer_bus_oe,
   output logic                             upper_byte_mask,
   output logic                             lower_byte_mask,
   output logic                             upper_column_strobe_n,
   output logic                             lower_column_strobe_n,
   output logic                             row_strobe_n,
   output logic                             write_en_n,
   output logic                             oe_bank_n,
   output logic                             chip_sel_n,
   output logic                             mem_clk,
   output logic                             mem_clk_en
);
   import dfb_pkg::*;

   // ==========================================================
   // declarations
   localparam int FW = DATA_W + BE_W;       // fifo word: be + data
   dfb_state_t         state;               // controller state
   logic [3:0]         wait_cnt;            // tick countdown
   logic [19:0]        init_cnt;            // power-up pause
   logic [15:0]        ref_cnt;             // refresh interval
   logic               ref_due;             // refresh pending
   logic [1:0]         init_refs;           // init refreshes left
   logic               op_read;             // current op is a read
   logic               last_read;           // fairness memory
   logic [WADDR_W-1:0] wr_addr;             // next write word
   logic [WADDR_W-1:0] rd_addr;             // next read word
   logic [WADDR_W-1:0] op_addr;             // word of current op
   logic               tick;                // memory clock fall
   logic               ref_start;           // refresh issued
   logic               fifo_valid;          // fifo has a word
   logic               fifo_pop;            // take fifo word
   logic [FW-1:0]      fifo_word;           // be + data
   logic               want_rd;             // refresh half needs data
   logic               grant_rd;            // read wins arbitration
   logic               grant_wr;            // write wins arbitration

   // ==========================================================
   // write fifo in front of the memory
   dfb_fifo #(
      .W     (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_valid  (pix_valid),
      .in_ready  (pix_ready),
      .in_data   ({pix_be, pix_data}),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_word)
   );

   // ==========================================================
   // memory clock: half of sys_clk; pins change on its fall
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) mem_clk <= 1'b0;
      else        mem_clk <= !mem_clk;
   end
   assign tick = mem_clk;

   // clock enable stays high: no power-down or suspend used
   assign mem_clk_en = 1'b1;

   // ==========================================================
   // arbitration between live writes and refresh reads
   assign want_rd  = rd_req && !rd_valid;
   assign grant_rd = dual_scan_en && want_rd &&
                     (!fifo_valid || !last_read);
   assign grant_wr = dual_scan_en && fifo_valid && !grant_rd;
   // pop when the write hold ends, or discard when memory is not in use
   assign fifo_pop = tick && ((state == DFB_CMD && !op_read &&
                     wait_cnt == 4'h0) ||
                     (state == DFB_IDLE && !dual_scan_en &&
                      fifo_valid));
   assign ref_start = tick && state == DFB_IDLE &&
                      (ref_due || init_refs != 2'h0);

   // ==========================================================
   // power-up pause
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)                   init_cnt <= '0;
      else if (state == DFB_POWERUP) init_cnt <= init_cnt + 1'b1;
   end

   // ==========================================================
   // refresh interval timer; a new request wins over the clear
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_cnt <= '0;
         ref_due <= 1'b0;
      end else begin
         if (ref_cnt == 16'(REF_CYCLES - 1)) begin
            ref_cnt <= '0;
            ref_due <= 1'b1;
         end else begin
            ref_cnt <= ref_cnt + 1'b1;
            if (ref_start) ref_due <= 1'b0;
         end
      end
   end

   // ==========================================================
   // frame buffer word addresses, restarted each frame
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_addr <= '0;
         rd_addr <= '0;
      end else if (frame_start) begin
         wr_addr <= '0;
         rd_addr <= '0;
      end else if (tick && state == DFB_IDLE && !ref_start) begin
         if (grant_rd)      rd_addr <= rd_addr + 1'b1;
         else if (grant_wr) wr_addr <= wr_addr + 1'b1;
      end
   end

   // ==========================================================
   // refresh-half read data holding register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid <= 1'b0;
         rd_data  <= '0;
      end else if (tick && state == DFB_CMD && op_read &&
                   wait_cnt == 4'h0) begin
         rd_valid <= 1'b1;                 // capture after latency
         rd_data  <= frame_buffer_bus_in;
      end else if (rd_valid && rd_ready) begin
         rd_valid <= 1'b0;
      end
   end

   // ==========================================================
   // controller and memory pins, updated on memory clock fall
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state                 <= DFB_POWERUP;
         wait_cnt              <= 4'h0;
         init_refs             <= INIT_REFS;
         op_read               <= 1'b0;
         last_read             <= 1'b0;
         op_addr               <= '0;
         mem_addr_bus          <= '0;
         frame_buffer_bus_out  <= '0;
         frame_buffer_bus_oe   <= 1'b0;
         upper_byte_mask       <= 1'b0;
         lower_byte_mask       <= 1'b0;
         upper_column_strobe_n <= 1'b1;
         lower_column_strobe_n <= 1'b1;
         row_strobe_n          <= 1'b1;
         write_en_n            <= 1'b1;
         oe_bank_n             <= 1'b1;
         chip_sel_n            <= 1'b1;
      end else if (tick) begin
         // default: no command, chip deselected
         chip_sel_n <= 1'b1;
         if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 1'b1;
         case (state)
            DFB_POWERUP: begin
               if (init_cnt >= 20'(INIT_WAIT)) begin
                  if (sdram_sel) begin
                     // precharge all banks
                     chip_sel_n   <= 1'b0;
                     row_strobe_n <= 1'b0;
                     write_en_n   <= 1'b0;
                     mem_addr_bus <= 11'(1 << AP_BIT);
                     oe_bank_n    <= 1'b0;
                     state        <= DFB_PRECHG;
                     wait_cnt     <= T_RP;
                  end else begin
                     state <= DFB_IDLE;
                  end
               end
            end
            DFB_PRECHG: begin
               row_strobe_n <= 1'b1;
               write_en_n   <= 1'b1;
               if (wait_cnt == 4'h0) begin
                  // load mode register
                  chip_sel_n            <= 1'b0;
                  row_strobe_n          <= 1'b0;
                  lower_column_strobe_n <= 1'b0;
                  write_en_n            <= 1'b0;
                  mem_addr_bus          <= MODE_WORD;
                  state                 <= DFB_MRS;
                  wait_cnt              <= T_RP;
               end
            end
            DFB_MRS: begin
               row_strobe_n          <= 1'b1;
               lower_column_strobe_n <= 1'b1;
               write_en_n            <= 1'b1;
               if (wait_cnt == 4'h0) state <= DFB_IDLE;
            end
            DFB_IDLE: begin
               upper_byte_mask <= 1'b0;
               lower_byte_mask <= 1'b0;
               if (ref_start) begin
                  // sdram auto refresh, edo cas-before-ras
                  if (init_refs != 2'h0) init_refs <= init_refs - 1'b1;
                  chip_sel_n            <= !sdram_sel;
                  row_strobe_n          <= !sdram_sel;
                  lower_column_strobe_n <= 1'b0;
                  upper_column_strobe_n <= sdram_sel;
                  state                 <= DFB_REF;
                  wait_cnt              <= T_RFC;
               end else if (grant_rd || grant_wr) begin
                  // activate the row of the chosen word
                  op_read      <= grant_rd;
                  last_read    <= grant_rd;
                  op_addr      <= grant_rd ? rd_addr : wr_addr;
                  chip_sel_n   <= !sdram_sel;
                  row_strobe_n <= 1'b0;
                  mem_addr_bus <= sdram_sel ?
                     (grant_rd ? rd_addr[WADDR_W-1:COL_W]
                               : wr_addr[WADDR_W-1:COL_W]) :
                     {1'b0, (grant_rd ? rd_addr[WADDR_W-2:COL_W]
                             : wr_addr[WADDR_W-2:COL_W])};
                  state        <= DFB_ACT;
                  wait_cnt     <= T_RCD;
               end
            end
            DFB_ACT: begin
               if (wait_cnt == 4'h0) begin
                  // column command; sdram auto precharges
                  chip_sel_n   <= !sdram_sel;
                  row_strobe_n <= sdram_sel;
                  mem_addr_bus <= {sdram_sel, 2'b00,
                                   op_addr[COL_W-1:0]};
                  write_en_n   <= op_read;
                  oe_bank_n    <= sdram_sel ? 1'b0 : !op_read;
                  if (op_read) begin
                     // both lanes kept open on reads
                     upper_byte_mask       <= 1'b0;
                     lower_byte_mask       <= 1'b0;
                     upper_column_strobe_n <= sdram_sel;
                     lower_column_strobe_n <= 1'b0;
                     wait_cnt              <= CAS_LAT;
                  end else begin
                     frame_buffer_bus_out  <= fifo_word[DATA_W-1:0];
                     frame_buffer_bus_oe   <= 1'b1;
                     // unwritten lanes masked (sdram) or not struck
                     upper_byte_mask       <= sdram_sel &&
                                              !fifo_word[FW-1];
                     lower_byte_mask       <= sdram_sel &&
                                              !fifo_word[FW-2];
                     upper_column_strobe_n <= sdram_sel ||
                                              !fifo_word[FW-1];
                     lower_column_strobe_n <= sdram_sel ?
                                              1'b0 : !fifo_word[FW-2];
                     wait_cnt              <= T_WR;
                  end
                  state <= DFB_CMD;
               end
            end
            DFB_CMD: begin
               // sdram sees one command; edo holds its strobes
               if (sdram_sel) begin
                  lower_column_strobe_n <= 1'b1;
                  write_en_n            <= 1'b1;
               end
               if (wait_cnt == 4'h0) begin
                  row_strobe_n          <= 1'b1;
                  upper_column_strobe_n <= 1'b1;
                  lower_column_strobe_n <= 1'b1;
                  write_en_n            <= 1'b1;
                  oe_bank_n             <= !sdram_sel;
                  frame_buffer_bus_oe   <= 1'b0;
                  state                 <= DFB_RECOV;
                  wait_cnt              <= T_RP;
               end
            end
            DFB_REF: begin
               // edo drops row strobe one tick after column strobe
               row_strobe_n <= sdram_sel;
               if (sdram_sel) lower_column_strobe_n <= 1'b1;
               if (wait_cnt == 4'h0) begin
                  row_strobe_n          <= 1'b1;
                  upper_column_strobe_n <= 1'b1;
                  lower_column_strobe_n <= 1'b1;
                  state                 <= DFB_RECOV;
                  wait_cnt              <= T_RP;
               end
            end
            DFB_RECOV: begin
               upper_byte_mask <= 1'b0;
               lower_byte_mask <= 1'b0;
               if (wait_cnt == 4'h0) state <= DFB_IDLE;
            end
            default: begin
               state <= DFB_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: bench/dfb_mem_if_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port-level checks of the memory interface
module dfb_mem_if_checker
   import dfb_pkg::*;
#(
   parameter int INIT_WAIT = 20   // power-up cycles of the dut
) (
   input wire logic              sys_clk,
   input wire logic              rst_n,
   input wire logic              sdram_sel,
   input wire logic              rd_ready,
   input wire logic              rd_valid,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic [ADDR_W-1:0] mem_addr_bus,
   input wire logic              frame_buffer_bus_oe,
   input wire logic              upper_byte_mask,
   input wire logic              lower_byte_mask,
   input wire logic              upper_column_strobe_n,
   input wire logic              lower_column_strobe_n,
   input wire logic              row_strobe_n,
   input wire logic              write_en_n,
   input wire logic              oe_bank_n,
   input wire logic              chip_sel_n,
   input wire logic              mem_clk,
   input wire logic              mem_clk_en
);
   // refresh gap ceiling
   localparam int REF_MAX = REF_CYCLES + INIT_WAIT + 100;
   logic cmd_rd, cmd_wr, cmd_ref;   // sdram commands on the pins
   int   ref_gap;                   // cycles since the last refresh
   assign cmd_rd = sdram_sel && !chip_sel_n && row_strobe_n && write_en_n;
   assign cmd_wr = sdram_sel && !chip_sel_n && row_strobe_n && !write_en_n
                   && !lower_column_strobe_n;
   assign cmd_ref = sdram_sel && !chip_sel_n && !row_strobe_n
                    && !lower_column_strobe_n && write_en_n;
   // refresh gap counter
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)       ref_gap <= 0;
      else if (cmd_ref) ref_gap <= 0;
      else              ref_gap <= ref_gap + 1;
   end
   default clocking dck @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // assertions
   a_mclk_toggle: assert property (
      $past(rst_n) |-> mem_clk != $past(mem_clk))
      else $error("mem_clk stuck");
   a_pins_on_tick: assert property (
      sdram_sel && $past(rst_n) && !$stable({chip_sel_n, row_strobe_n,
      lower_column_strobe_n, write_en_n, mem_addr_bus}) |-> $fell(mem_clk))
      else $error("pins off tick");
   a_read_latency: assert property (
      $fell(lower_column_strobe_n) && cmd_rd |-> ##6 $rose(rd_valid))
      else $error("read latency");
   a_write_drives: assert property (
      $fell(lower_column_strobe_n) && cmd_wr |-> frame_buffer_bus_oe)
      else $error("write not driven");
   a_mask_on_write: assert property (
      sdram_sel && ($rose(upper_byte_mask) || $rose(lower_byte_mask))
      |-> cmd_wr)
      else $error("stray mask");
   a_bank_fixed: assert property (
      sdram_sel && !chip_sel_n |-> !oe_bank_n)
      else $error("bank moved");
   a_upper_unused: assert property (
      sdram_sel |-> upper_column_strobe_n)
      else $error("upper strobe used");
   a_edo_addr: assert property (
      !sdram_sel |-> !mem_addr_bus[10])
      else $error("edo bit ten set");
   a_cke_high: assert property (mem_clk_en)
      else $error("clock enable dropped");
   a_refresh_gap: assert property (
      sdram_sel |-> ref_gap < REF_MAX)
      else $error("refresh overdue");
   a_read_held: assert property (
      rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("read word dropped before taken");
endmodule
bind dfb_mem_if dfb_mem_if_checker #(.INIT_WAIT(INIT_WAIT)) i_chk (
   .sys_clk, .rst_n, .sdram_sel, .rd_ready, .rd_valid, .rd_data,
   .mem_addr_bus, .frame_buffer_bus_oe, .upper_byte_mask, .lower_byte_mask,
   .upper_column_strobe_n, .lower_column_strobe_n, .row_strobe_n,
   .write_en_n, .oe_bank_n, .chip_sel_n, .mem_clk, .mem_clk_en);
`default_nettype wire

// File: bench/dfb_sdram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// behavioural sdram frame buffer, one bank, burst of one
module dfb_sdram_model (
   input  wire logic        mem_clk,
   input  wire logic        chip_sel_n,
   input  wire logic        row_strobe_n,
   input  wire logic        col_strobe_n,
   input  wire logic        write_en_n,
   input  wire logic [10:0] addr,
   input  wire logic [15:0] dq_in,
   input  wire logic [1:0]  dqm,
   output logic      [15:0] dq_out,
   output int               wr_cnt
);
   logic [15:0] mem [int];        // written words by word address
   logic [10:0] row = 11'h000;    // open row
   logic [7:0]  col1, col2;       // read column pipeline
   logic [1:0]  msk1, msk2;       // read lane mask pipeline
   logic        rd1 = 1'b0, rd2 = 1'b0;
   logic [15:0] w;
   initial dq_out = 16'h0000;
   initial wr_cnt = 0;
   // unwritten words read back a fixed address pattern
   function automatic logic [15:0] peek(input int a);
      return mem.exists(a) ? mem[a] : (a[15:0] ^ 16'hA5C3);
   endfunction
   // commands sampled on mem_clk rise; clock enable ignored
   always @(posedge mem_clk) begin
      if (!chip_sel_n && !row_strobe_n && col_strobe_n && write_en_n) begin
         row <= addr;   // activate opens a row
      end
      rd1 <= !chip_sel_n && row_strobe_n && !col_strobe_n && write_en_n;
      col1 <= addr[7:0];
      msk1 <= dqm;
      rd2 <= rd1;
      col2 <= col1;
      msk2 <= msk1;
      if (!chip_sel_n && row_strobe_n && !col_strobe_n && !write_en_n) begin
         w = peek({row, addr[7:0]});
         if (!dqm[1]) w[15:8] = dq_in[15:8];   // masked lane kept
         if (!dqm[0]) w[7:0] = dq_in[7:0];     // lower lane
         mem[{row, addr[7:0]}] = w;
         wr_cnt <= wr_cnt + 1;
      end
      // read data two rises on, masked lanes float
      if (rd2) begin
         w = peek({row, col2});
         if (msk2[1]) w[15:8] = ~dq_out[15:8];
         if (msk2[0]) w[7:0] = ~dq_out[7:0];
         dq_out <= w;
      end else begin
         dq_out <= ~dq_out;   // released bus keeps moving
      end
   end
endmodule
`default_nettype wire

// File: bench/dfb_mem_if_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((e) !== (s)) begin \
   error_cnt++; $display("Error %s exp %0h got %0h", n, e, s); end end
// ==========================================================
// bench top
module dfb_mem_if_test;
   import dfb_pkg::*;
   logic        sys_clk = 1'b0;      // 250 MHz pixel clock
   logic        rst_n = 1'b0;
   logic        sdram_sel = 1'b1;
   logic        dual_scan_en = 1'b1;
   logic        frame_start = 1'b0;
   logic        pix_valid = 1'b0;
   logic [15:0] pix_data = 16'h0000;
   logic [1:0]  pix_be = 2'h0;
   logic        rd_req = 1'b0;
   logic        rd_ready = 1'b0;
   logic        pix_ready, rd_valid, frame_buffer_bus_oe, mem_clk;
   logic        upper_byte_mask, lower_byte_mask, mem_clk_en;
   logic        upper_column_strobe_n, lower_column_strobe_n;
   logic        row_strobe_n, write_en_n, oe_bank_n, chip_sel_n;
   logic [15:0] rd_data, frame_buffer_bus_in, frame_buffer_bus_out;
   logic [10:0] mem_addr_bus;
   int          wr_cnt;
   int          error_cnt = 0, check_count = 0, cyc = 0;
   int          lo_cnt = 0, up_cnt = 0;   // edo write strobe falls
   logic [31:0] seed = 32'h225C;   // xorshift state
   logic [15:0] exp_mem [int];     // reference frame buffer
   logic        saw_full = 1'b0;
   logic        pl = 1'b1, pu = 1'b1;     // previous strobe levels
   dfb_mem_if #(.INIT_WAIT(20)) i_dut (
      .sys_clk, .rst_n, .sdram_sel, .dual_scan_en, .frame_start,
      .pix_valid, .pix_ready, .pix_data, .pix_be, .rd_req, .rd_valid,
      .rd_ready, .rd_data, .mem_addr_bus, .frame_buffer_bus_in,
      .frame_buffer_bus_out, .frame_buffer_bus_oe, .upper_byte_mask,
      .lower_byte_mask, .upper_column_strobe_n, .lower_column_strobe_n,
      .row_strobe_n, .write_en_n, .oe_bank_n, .chip_sel_n, .mem_clk,
      .mem_clk_en);
   dfb_sdram_model i_mem (
      .mem_clk, .chip_sel_n, .row_strobe_n, .write_en_n,
      .col_strobe_n(lower_column_strobe_n), .addr(mem_addr_bus),
      .dq_in(frame_buffer_bus_out),
      .dqm({upper_byte_mask, lower_byte_mask}),
      .dq_out(frame_buffer_bus_in), .wr_cnt);
   initial forever #2 sys_clk = ~sys_clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // short reset keeps the run brief
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask
   task automatic pulse_frame();
      frame_start <= 1'b1;
      @(posedge sys_clk);
      frame_start <= 1'b0;
   endtask
   // offer one word until taken
   task automatic push(input logic [15:0] d, input logic [1:0] b);
      pix_valid <= 1'b1;
      pix_data <= d;
      pix_be <= b;
      @(negedge sys_clk);
      while (pix_ready !== 1'b1) begin
         saw_full = 1'b1;
         @(negedge sys_clk);
      end
      @(posedge sys_clk);
   endtask
   // take one read word, random stalls
   task automatic pull(output logic [15:0] d);
      logic        v;
      logic [31:0] r;
      do begin
         r = rnd();
         rd_ready <= r[0] | r[1];
         @(negedge sys_clk);
         v = rd_valid & rd_ready;
         d = rd_data;
         @(posedge sys_clk);
      end while (v !== 1'b1);
   endtask
   // edo write strobe monitor
   always @(negedge sys_clk) begin
      if (!sdram_sel && !write_en_n) begin
         if (pl && !lower_column_strobe_n) lo_cnt++;
         if (pu && !upper_column_strobe_n) up_cnt++;
      end
      pl = lower_column_strobe_n;
      pu = upper_column_strobe_n;
   end
   // hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         stop_test();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] r;
      logic [15:0] d, old;
      do_reset();
      pulse_frame();
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         push(r[15:0], r[17:16]);
         old = i[15:0] ^ 16'hA5C3;
         exp_mem[i] = {r[17] ? r[15:8] : old[15:8],
                       r[16] ? r[7:0] : old[7:0]};
      end
      pix_valid <= 1'b0;
      `CHK("fifo full", 1'b1, saw_full)
      for (int k = 0; k < 3000 && wr_cnt < 40; k++) @(posedge sys_clk);
      `CHK("writes", 40, wr_cnt)
      pulse_frame();
      rd_req <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         pull(d);
         `CHK("read word", exp_mem[i], d)
      end
      rd_req <= 1'b0;
      rd_ready <= 1'b0;
      dual_scan_en <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         push(r[15:0], 2'h3);
      end
      pix_valid <= 1'b0;
      repeat (100) @(posedge sys_clk);
      `CHK("no traffic", 40, wr_cnt)
      sdram_sel <= 1'b0;
      dual_scan_en <= 1'b1;
      do_reset();
      pulse_frame();
      for (int i = 0; i < 4; i++) begin
         r = rnd();
         push(r[15:0], 2'h1);
      end
      pix_valid <= 1'b0;
      for (int k = 0; k < 2000 && lo_cnt < 4; k++) @(posedge sys_clk);
      repeat (40) @(posedge sys_clk);
      `CHK("edo lower strobes", 4, lo_cnt)
      `CHK("edo upper strobes", 0, up_cnt)
      stop_test();
   end
endmodule
`default_nettype wire
